// file: src/rbfs_slave.sv
// Binary serial frame slave: gap framing, check value, command decode, answers
`timescale 1ns/1ps
module rbfs_slave #(
   parameter int unsigned GAP_CYCLES = rbfs_pkg::GAP_CYCLES,
   parameter int BUF_DEPTH = 2
) (
   input wire logic mclk, // Clock, 200 MHz
   input wire logic rstn, // Synchronous reset, active low
   input wire logic [5:0] station_id, // Own station number, strap
   input wire logic [7:0] rx_data, // Received byte
   input wire logic rx_valid, // Received byte strobe
   output logic [7:0] tx_data, // Byte to send
   output logic tx_valid, // Byte to send available
   input wire logic tx_ready, // Transmitter takes byte
   output logic par_req, // Parameter access pulse
   output logic par_we, // Access is a write
   output logic [15:0] par_addr, // Parameter address
   output logic [15:0] par_wdata, // Value to write
   input wire logic par_ack, // Access done pulse
   input wire logic [15:0] par_rdata, // Value read
   input wire logic par_addr_err, // Address invalid, with ack
   input wire logic par_range_err, // Value out of range, with ack
   output logic frame_drop // Frame silently discarded, pulse
);
   localparam int CW = $clog2(GAP_CYCLES + 1);
   localparam logic [CW-1:0] GAP_LAST = CW'(GAP_CYCLES - 1);
   localparam logic [CW-1:0] GAP_FULL = CW'(GAP_CYCLES);

   rbfs_pkg::rbfs_state_e state;
   rbfs_pkg::rbfs_kind_e kind;

   logic [5:0] stn_s1;
   logic [5:0] stn_s2;
   logic [CW-1:0] idle_cnt;
   logic gap_hit;
   logic armed;
   logic [6:0] cnt;
   logic ovf;
   logic [7:0] stn;
   logic [7:0] cmd;
   logic [7:0] dat [4];
   logic [7:0] b_last;
   logic [7:0] b_prev;
   logic [15:0] crc_excl;
   logic [15:0] req_n;
   logic [15:0] req_addr;
   logic crc_ok;
   logic stn_ok;
   logic len_ok;
   logic [7:0] exc_code;
   logic [5:0] widx;
   logic [6:0] idx;
   logic [6:0] tx_len;
   logic [15:0] word;
   logic word_held;
   logic [15:0] crc_tx;
   logic [7:0] out_byte;
   logic need_fetch;
   logic buf_valid;
   logic buf_ready;
   logic push;

   // ***********************************************************
   // Station strap synchroniser
   // ***********************************************************
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         stn_s1 <= 6'h00;
         stn_s2 <= 6'h00;
      end else begin
         stn_s1 <= station_id;
         stn_s2 <= stn_s1;
      end
   end

   // ***********************************************************
   // Idle gap timing
   // ***********************************************************
   assign gap_hit = !rx_valid && (idle_cnt == GAP_LAST);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         idle_cnt <= '0;
      end else if (rx_valid) begin
         idle_cnt <= '0;
      end else if (idle_cnt != GAP_FULL) begin
         idle_cnt <= idle_cnt + 1'b1;
      end
   end

   // Bytes are only taken after a full gap, so a frame joined midway is never parsed
   // The gap that closes a frame also opens the next; only busy-time bytes disarm
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         armed <= 1'b0;
      end else if (gap_hit) begin
         armed <= 1'b1;
      end else if (rx_valid && state != rbfs_pkg::ST_RX) begin
         armed <= 1'b0;
      end
   end

   // ***********************************************************
   // Frame capture and check over all but the last two bytes
   // ***********************************************************
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cnt <= 7'h00;
         ovf <= 1'b0;
         stn <= 8'h00;
         cmd <= 8'h00;
         dat <= '{default: 8'h00};
         b_last <= 8'h00;
         b_prev <= 8'h00;
         crc_excl <= rbfs_pkg::CRC_INIT;
      end else if (state == rbfs_pkg::ST_EVAL) begin
         cnt <= 7'h00;
         ovf <= 1'b0;
      end else if (state == rbfs_pkg::ST_RX && rx_valid && armed) begin
         if (cnt == rbfs_pkg::MAX_FRAME) begin
            ovf <= 1'b1;
         end else begin
            cnt <= cnt + 7'h01;
         end
         if (cnt == 7'h00) begin
            stn <= rx_data;
         end
         if (cnt == 7'h01) begin
            cmd <= rx_data;
         end
         if (cnt >= 7'h02 && cnt <= 7'h05) begin
            dat[2'(cnt - 7'h02)] <= rx_data;
         end
         b_prev <= b_last;
         b_last <= rx_data;
         // The fold lags two bytes so the check bytes never enter it
         if (cnt == 7'h00) begin
            crc_excl <= rbfs_pkg::CRC_INIT;
         end else if (cnt >= 7'h02) begin
            crc_excl <= rbfs_pkg::crc_byte(crc_excl, b_prev);
         end
      end
   end

   // ***********************************************************
   // Frame evaluation
   // ***********************************************************
   assign req_addr = {dat[0], dat[1]};
   assign req_n = {dat[2], dat[3]};
   // Check bytes arrive low then high
   assign crc_ok = (cnt >= rbfs_pkg::FRAME_OVH) && !ovf
                   && ({b_last, b_prev} == crc_excl);
   assign stn_ok = (stn[5:0] == stn_s2) && (stn[7:6] == 2'b00)
                   && (stn_s2 >= rbfs_pkg::STN_MIN) && (stn_s2 <= rbfs_pkg::STN_MAX);
   assign len_ok = (cnt == rbfs_pkg::REQ_LEN);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         frame_drop <= 1'b0;
      end else begin
         frame_drop <= (state == rbfs_pkg::ST_EVAL) && !(crc_ok && stn_ok);
      end
   end

   // ***********************************************************
   // Answer byte selection
   // ***********************************************************
   always_comb begin
      out_byte = 8'h00;
      if (idx == tx_len - 7'h02) begin
         out_byte = crc_tx[7:0];
      end else if (idx == tx_len - 7'h01) begin
         out_byte = crc_tx[15:8];
      end else if (idx == 7'h00) begin
         out_byte = stn;
      end else if (idx == 7'h01) begin
         out_byte = (kind == rbfs_pkg::RK_EXC) ? (cmd | rbfs_pkg::EXC_FLAG) : cmd;
      end else if (kind == rbfs_pkg::RK_EXC) begin
         out_byte = exc_code;
      end else if (kind == rbfs_pkg::RK_ECHO) begin
         out_byte = dat[2'(idx - 7'h02)];
      end else if (idx == 7'h02) begin
         out_byte = {req_n[6:0], 1'b0};
      end else begin
         out_byte = idx[0] ? word[15:8] : word[7:0];
      end
   end

   assign need_fetch = (kind == rbfs_pkg::RK_READ) && (idx >= 7'h03)
                       && (idx < tx_len - 7'h02) && idx[0] && !word_held;
   assign buf_valid = (state == rbfs_pkg::ST_TX) && !need_fetch;
   assign push = buf_valid && buf_ready;

   // ***********************************************************
   // Sequencer and parameter access
   // ***********************************************************
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state <= rbfs_pkg::ST_RX;
         kind <= rbfs_pkg::RK_EXC;
         exc_code <= 8'h00;
         par_req <= 1'b0;
         par_we <= 1'b0;
         par_addr <= 16'h0000;
         par_wdata <= 16'h0000;
         widx <= 6'h00;
         idx <= 7'h00;
         tx_len <= 7'h00;
         word <= 16'h0000;
         word_held <= 1'b0;
         crc_tx <= rbfs_pkg::CRC_INIT;
      end else begin
         par_req <= 1'b0;
         case (state)
            rbfs_pkg::ST_RX: begin
               if (gap_hit && cnt != 7'h00) begin
                  state <= rbfs_pkg::ST_EVAL;
               end
            end
            rbfs_pkg::ST_EVAL: begin
               idx <= 7'h00;
               crc_tx <= rbfs_pkg::CRC_INIT;
               word_held <= 1'b0;
               tx_len <= rbfs_pkg::EXC_LEN;
               kind <= rbfs_pkg::RK_EXC;
               if (!(crc_ok && stn_ok)) begin
                  state <= rbfs_pkg::ST_RX;
               end else if (cmd == rbfs_pkg::CMD_READ) begin
                  if (!len_ok || req_n == 16'h0000 || req_n > rbfs_pkg::MAX_WORDS) begin
                     exc_code <= rbfs_pkg::EXC_RANGE;
                     state <= rbfs_pkg::ST_TX;
                  end else begin
                     // First pass only probes addresses, so errors are known before any byte
                     par_req <= 1'b1;
                     par_we <= 1'b0;
                     par_addr <= req_addr;
                     widx <= 6'h00;
                     state <= rbfs_pkg::ST_PROBE;
                  end
               end else if (cmd == rbfs_pkg::CMD_WRITE) begin
                  if (!len_ok) begin
                     exc_code <= rbfs_pkg::EXC_RANGE;
                     state <= rbfs_pkg::ST_TX;
                  end else begin
                     par_req <= 1'b1;
                     par_we <= 1'b1;
                     par_addr <= req_addr;
                     par_wdata <= req_n;
                     state <= rbfs_pkg::ST_WRITE;
                  end
               end else if (cmd == rbfs_pkg::CMD_DIAG) begin
                  if (!len_ok) begin
                     exc_code <= rbfs_pkg::EXC_RANGE;
                  end else begin
                     kind <= rbfs_pkg::RK_ECHO;
                     tx_len <= rbfs_pkg::ECHO_LEN;
                  end
                  state <= rbfs_pkg::ST_TX;
               end else begin
                  exc_code <= rbfs_pkg::EXC_BAD_CMD;
                  state <= rbfs_pkg::ST_TX;
               end
            end
            rbfs_pkg::ST_PROBE: begin
               if (par_ack) begin
                  if (par_addr_err) begin
                     exc_code <= rbfs_pkg::EXC_BAD_ADDR;
                     state <= rbfs_pkg::ST_TX;
                  end else if ({10'h000, widx} == req_n - 16'h0001) begin
                     kind <= rbfs_pkg::RK_READ;
                     tx_len <= rbfs_pkg::READ_OVH + {req_n[5:0], 1'b0};
                     widx <= 6'h00;
                     state <= rbfs_pkg::ST_TX;
                  end else begin
                     par_req <= 1'b1;
                     par_addr <= req_addr + {10'h000, widx} + 16'h0001;
                     widx <= widx + 6'h01;
                  end
               end
            end
            rbfs_pkg::ST_WRITE: begin
               if (par_ack) begin
                  if (par_addr_err) begin
                     exc_code <= rbfs_pkg::EXC_BAD_ADDR;
                  end else if (par_range_err) begin
                     exc_code <= rbfs_pkg::EXC_RANGE;
                  end else begin
                     kind <= rbfs_pkg::RK_ECHO;
                     tx_len <= rbfs_pkg::ECHO_LEN;
                  end
                  state <= rbfs_pkg::ST_TX;
               end
            end
            rbfs_pkg::ST_TX: begin
               if (need_fetch) begin
                  par_req <= 1'b1;
                  par_we <= 1'b0;
                  par_addr <= req_addr + {10'h000, widx};
                  state <= rbfs_pkg::ST_FETCH;
               end else if (push) begin
                  idx <= idx + 7'h01;
                  if (idx < tx_len - 7'h02) begin
                     crc_tx <= rbfs_pkg::crc_byte(crc_tx, out_byte);
                  end
                  if (kind == rbfs_pkg::RK_READ && idx >= 7'h04 && !idx[0]) begin
                     word_held <= 1'b0;
                  end
                  if (idx == tx_len - 7'h01) begin
                     state <= rbfs_pkg::ST_RX;
                  end
               end
            end
            rbfs_pkg::ST_FETCH: begin
               if (par_ack) begin
                  word <= par_rdata;
                  word_held <= 1'b1;
                  widx <= widx + 6'h01;
                  state <= rbfs_pkg::ST_TX;
               end
            end
            default: begin
               state <= rbfs_pkg::ST_RX;
            end
         endcase
      end
   end

   // ***********************************************************
   // Output buffer, absorbs transmitter stalls
   // ***********************************************************
   rbfs_buf #(.W(8), .DEPTH(BUF_DEPTH)) u_buf (
      .mclk(mclk),
      .rstn(rstn),
      .in_data(out_byte),
      .in_valid(buf_valid),
      .in_ready(buf_ready),
      .out_data(tx_data),
      .out_valid(tx_valid),
      .out_ready(tx_ready)
   );

   // ***********************************************************
   // Checks
   // ***********************************************************
   a_gap_arm: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(armed) |-> $past(idle_cnt) == GAP_LAST)
      else $error("armed without full idle gap");
   a_gap_end: assert property (@(posedge mclk) disable iff (!rstn)
      (state == rbfs_pkg::ST_RX && gap_hit && cnt != 7'h00) |=> state == rbfs_pkg::ST_EVAL)
      else $error("frame not closed by gap");
   a_stn_drop: assert property (@(posedge mclk) disable iff (!rstn)
      (state == rbfs_pkg::ST_EVAL && !stn_ok) |=> (state == rbfs_pkg::ST_RX && frame_drop))
      else $error("other station frame not dropped");
   a_crc_drop: assert property (@(posedge mclk) disable iff (!rstn)
      (state == rbfs_pkg::ST_EVAL && !crc_ok) |=> !buf_valid ##1 !buf_valid)
      else $error("bad check frame answered");
   a_crc_seed: assert property (@(posedge mclk) disable iff (!rstn)
      (state == rbfs_pkg::ST_TX && idx == 7'h00) |-> crc_tx == rbfs_pkg::CRC_INIT)
      else $error("check register not seeded");
   a_crc_order: assert property (@(posedge mclk) disable iff (!rstn)
      (push && idx == tx_len - 7'h02) |=> (idx == tx_len - 7'h01)
      && out_byte == $past(crc_tx[15:8]))
      else $error("check high byte not after low");
   a_exc_cmd: assert property (@(posedge mclk) disable iff (!rstn)
      (push && kind == rbfs_pkg::RK_EXC && idx == 7'h01) |-> out_byte == (cmd | 8'h80))
      else $error("exception command wrong");
   a_bad_cmd: assert property (@(posedge mclk) disable iff (!rstn)
      (state == rbfs_pkg::ST_EVAL && crc_ok && stn_ok && cmd != 8'h03 && cmd != 8'h06
      && cmd != 8'h08) |=> (kind == rbfs_pkg::RK_EXC && exc_code == 8'h01))
      else $error("unknown command not code 01h");
   a_read_limit: assert property (@(posedge mclk) disable iff (!rstn)
      (state == rbfs_pkg::ST_PROBE) |-> (req_n >= 16'h0001 && req_n <= rbfs_pkg::MAX_WORDS))
      else $error("read count over limit");
   a_write_args: assert property (@(posedge mclk) disable iff (!rstn)
      (par_req && par_we) |-> (par_addr == req_addr && par_wdata == req_n))
      else $error("write access arguments wrong");
   a_read_count: assert property (@(posedge mclk) disable iff (!rstn)
      (push && kind == rbfs_pkg::RK_READ && idx == 7'h02) |-> tx_len == out_byte[6:0] + 7'h05)
      else $error("read byte count wrong");

endmodule

// file: src/rbfs_pkg.sv
// Shared constants, types and check-value function for the binary frame slave
package rbfs_pkg;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned GAP_US = 6000;
   localparam int unsigned GAP_CYCLES = (CLK_HZ / 1_000_000) * GAP_US;

   // ***********************************************************
   // Check value
   // ***********************************************************
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam int CRC_SHIFTS = 8;

   // ***********************************************************
   // Commands, exception codes, stations
   // ***********************************************************
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_WRITE = 8'h06;
   localparam logic [7:0] CMD_DIAG = 8'h08;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_BAD_CMD = 8'h01;
   localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
   localparam logic [7:0] EXC_RANGE = 8'h03;
   localparam logic [5:0] STN_MIN = 6'h01;
   localparam logic [5:0] STN_MAX = 6'h20;
   localparam logic [15:0] MAX_WORDS = 16'h001D;

   // ***********************************************************
   // Frame lengths in bytes
   // ***********************************************************
   localparam logic [6:0] FRAME_OVH = 7'h04;
   localparam logic [6:0] REQ_LEN = 7'h08;
   localparam logic [6:0] MAX_FRAME = 7'h3E;
   localparam logic [6:0] EXC_LEN = 7'h05;
   localparam logic [6:0] ECHO_LEN = 7'h08;
   localparam logic [6:0] READ_OVH = 7'h05;

   typedef enum logic [1:0] {RK_READ, RK_ECHO, RK_EXC} rbfs_kind_e;
   typedef enum logic [2:0] {ST_RX, ST_EVAL, ST_PROBE, ST_WRITE, ST_TX, ST_FETCH} rbfs_state_e;

   // Folds one byte into the check register, eight right shifts
   function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < CRC_SHIFTS; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

endpackage

// file: src/rbfs_buf.sv
// Small valid/ready byte buffer between the answer builder and the transmitter
`timescale 1ns/1ps
module rbfs_buf #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   input wire logic mclk, // Clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic [W-1:0] in_data, // Word to store
   input wire logic in_valid, // Word offered
   output logic in_ready, // Room for a word
   output logic [W-1:0] out_data, // Oldest word
   output logic out_valid, // Word available
   input wire logic out_ready // Drain accepts
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic do_wr;
   logic do_rd;

   assign in_ready = (count != FULL);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   always_ff @(posedge mclk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count <= count + 1'b1;
         end else if (do_rd && !do_wr) begin
            count <= count - 1'b1;
         end
      end
   end

endmodule

// file: verification/rbfs_par_model.sv
// Parameter space stand-in that answers the slave's access requests
`timescale 1ns/1ps
module rbfs_par_model (
   input wire logic mclk, // Clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic [3:0] lat, // Answer delay in cycles, 1 or more
   input wire logic par_req, // Access request pulse
   input wire logic par_we, // Access is a write
   input wire logic [15:0] par_addr, // Address
   input wire logic [15:0] par_wdata, // Write value
   output logic par_ack, // Done pulse
   output logic [15:0] par_rdata, // Read value
   output logic par_addr_err, // Address invalid
   output logic par_range_err // Write value out of range
);
   logic [3:0] cnt;
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cnt <= 4'h0;
         par_ack <= 1'b0;
         par_rdata <= 16'h0000;
         par_addr_err <= 1'b0;
         par_range_err <= 1'b0;
      end else begin
         cnt <= par_req ? lat : ((cnt != 4'h0) ? cnt - 4'h1 : 4'h0);
         par_ack <= (cnt == 4'h1);
         if (cnt == 4'h1) begin
            par_rdata <= {par_addr[7:0], ~par_addr[7:0]};
            par_addr_err <= (par_addr >= 16'h0300);
            par_range_err <= par_we && (par_wdata > 16'h00FF);
         end else begin
            // Outside an answer nothing repeats, so a late sample shows
            par_rdata <= ~par_rdata;
            par_addr_err <= ~par_addr_err;
            par_range_err <= ~par_range_err;
         end
      end
   end
endmodule

// file: verification/rbfs_slave_tb.sv
// Self-checking bench for the binary frame slave
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module rbfs_slave_tb;
   // ****************************************
   // Harness
   // ****************************************
   localparam int GAP = 50;
   typedef logic [7:0] rbfs_bq_t [$];
   logic mclk = 1'b0, rstn = 1'b0, rx_valid = 1'b0, tx_ready = 1'b1, stall = 1'b0;
   logic [5:0] station_id = 6'h01;
   logic [7:0] rx_data = 8'h00, tx_data;
   logic [3:0] lat = 4'h2;
   logic tx_valid, par_req, par_we, par_ack, par_addr_err, par_range_err, frame_drop;
   logic [15:0] par_addr, par_wdata, par_rdata;
   int fail_count = 0, samples_checked = 0, drops = 0, cyc = 0;
   rbfs_bq_t got;
   rbfs_slave #(.GAP_CYCLES(GAP)) i_dut (.mclk(mclk), .rstn(rstn), .station_id(station_id),
      .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .par_req(par_req), .par_we(par_we), .par_addr(par_addr),
      .par_wdata(par_wdata), .par_ack(par_ack), .par_rdata(par_rdata),
      .par_addr_err(par_addr_err), .par_range_err(par_range_err), .frame_drop(frame_drop));
   rbfs_par_model i_par (.mclk(mclk), .rstn(rstn), .lat(lat), .par_req(par_req),
      .par_we(par_we), .par_addr(par_addr), .par_wdata(par_wdata), .par_ack(par_ack),
      .par_rdata(par_rdata), .par_addr_err(par_addr_err), .par_range_err(par_range_err));
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (rstn && tx_valid === 1'b1 && tx_ready) got.push_back(tx_data);
      if (frame_drop === 1'b1) drops++;
      if (cyc == 40000) begin
         fail_count++;
         wrap_up();
      end
   end
   // Stalled receiver takes one byte in three
   always @(negedge mclk) tx_ready <= !stall || (cyc % 3 == 0);
   function automatic logic [15:0] crc16(rbfs_bq_t q);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction
   // Sends a request after pre idle cycles; bad spoils its check value
   task automatic txn(input int pre, input rbfs_bq_t req, input rbfs_bq_t rsp,
      input logic bad, input int ndrop);
      logic [15:0] c;
      int d0;
      int w;
      c = crc16(req) ^ {15'h0000, bad};
      req = {req, c[7:0], c[15:8]};
      c = crc16(rsp);
      if (rsp.size() > 0) rsp = {rsp, c[7:0], c[15:8]};
      repeat (pre) @(negedge mclk);
      got = {};
      d0 = drops;
      foreach (req[i]) begin
         rx_data <= req[i];
         rx_valid <= 1'b1;
         @(negedge mclk);
         rx_valid <= 1'b0;
         @(negedge mclk);
      end
      w = 0;
      while (got.size() < rsp.size() && w < 4000) begin
         @(negedge mclk);
         w++;
      end
      repeat (GAP + 40) @(negedge mclk);
      `CHK("answer length", rsp.size(), got.size())
      foreach (rsp[i]) if (i < got.size()) `CHK("answer byte", rsp[i], got[i])
      `CHK("drop count", ndrop, drops - d0)
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_read();
      rbfs_bq_t q;
      rbfs_bq_t r;
      q = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 8'h02};
      `CHK("request check", 16'hB3C5, crc16(q))
      stall = 1'b1;
      txn(GAP, q, '{8'h01, 8'h03, 8'h04, 8'h00, 8'hFF, 8'h01, 8'hFE}, 0, 0);
      r = '{8'h01, 8'h03, 8'h3A};
      for (int i = 0; i < 29; i++) r = {r, 8'h10 + 8'(i), ~(8'h10 + 8'(i))};
      txn(GAP, '{8'h01, 8'h03, 8'h00, 8'h10, 8'h00, 8'h1D}, r, 0, 0);
      stall = 1'b0;
   endtask
   task automatic t_write_diag();
      rbfs_bq_t q;
      q = '{8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64};
      txn(0, q, '{}, 0, 0);
      lat = 4'h9;
      txn(GAP, q, q, 0, 0);
      lat = 4'h1;
      q = '{8'h01, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h5A};
      txn(GAP, q, q, 0, 0);
   endtask
   task automatic t_exc();
      logic [7:0] t [6][6];
      t = '{'{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h06, 8'h04, 8'h00, 8'h00, 8'h01, 8'h02},
         '{8'h06, 8'h02, 8'h00, 8'h12, 8'h34, 8'h03}, '{8'h03, 8'h02, 8'h00, 8'h00, 8'h1E, 8'h03},
         '{8'h03, 8'h02, 8'h00, 8'h00, 8'h00, 8'h03}, '{8'h03, 8'h02, 8'hFF, 8'h00, 8'h02, 8'h02}};
      foreach (t[i]) begin
         txn(GAP, '{8'h01, t[i][0], t[i][1], t[i][2], t[i][3], t[i][4]},
            '{8'h01, t[i][0] | 8'h80, t[i][5]}, 0, 0);
      end
   endtask
   task automatic t_drop();
      rbfs_bq_t q;
      q = '{8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64};
      txn(GAP, q, '{}, 1, 1);
      q[0] = 8'h02;
      txn(GAP, q, '{}, 0, 1);
      station_id = 6'h20;
      q[0] = 8'h20;
      txn(GAP, q, q, 0, 0);
      station_id = 6'h01;
   endtask
   initial begin
      repeat (16) @(negedge mclk);
      rstn = 1'b1;
      t_write_diag();
      t_read();
      t_exc();
      t_drop();
      wrap_up();
   end
endmodule
